// *** logic/dpram_regs.svh ***
`ifndef DPRAM_REGS_SVH
`define DPRAM_REGS_SVH

// ---------------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------------
`define CLK_PERIOD_NS       8
`define REFRESH_INTERVAL_NS 15600
`define REFRESH_INTERVAL_CYC (`REFRESH_INTERVAL_NS / `CLK_PERIOD_NS)
`define ACCESS_NS           100
`define ACCESS_CYC ((`ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_NS          200
`define REFRESH_CYC ((`REFRESH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ---------------------------------------------------------------------
// memory map
// ---------------------------------------------------------------------
`define LOCAL_BASE      20'h00000
`define BASE_LIMIT      21'h008000
`define EXP_LIMIT       21'h010000
`define SEG_SHIFT_BASE  13
`define SEG_SHIFT_EXP   14
`define BASE_ALIGN      3
`define MEM_WORDS       32768

`endif

// *** logic/dpram_pkg.sv ***
package dpram_pkg;

  typedef enum logic [4:0] {
    ST_IDLE     = 5'h01,
    ST_REFRESH  = 5'h02,
    ST_LOCAL    = 5'h04,
    ST_SYSTEM   = 5'h08,
    ST_SYS_HOLD = 5'h10
  } arb_state_e;

  typedef logic [19:0] addr_t;
  typedef logic [15:0] word_t;
  typedef logic [7:0]  cnt_t;
  typedef logic [11:0] tick_t;

endpackage

// *** logic/refresh_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dpram_regs.svh"

module refresh_timer
  import dpram_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic served,
  output var  logic pending
);

  tick_t count;

  // ---------------------------------------------------------------------
  // interval counter, free running so refresh never drifts
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
    end else if (count == tick_t'(`REFRESH_INTERVAL_CYC - 1)) begin
      count <= '0;
    end else begin
      count <= count + tick_t'(1);
    end
  end

  // ---------------------------------------------------------------------
  // sticky request; a new tick wins over the clear
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pending <= 1'b0;
    end else if (count == tick_t'(`REFRESH_INTERVAL_CYC - 1)) begin
      pending <= 1'b1;
    end else if (served) begin
      pending <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// *** logic/dual_port_ram_control.sv ***
// Function
// - refresh always wins the next grant
// - local processor beats system bus
// - separate address decode per port
// - local port sees memory from zero
// - system base jumpered, 8-byte aligned
// - block system access to contiguous segments
// - system port does bytes and words
// - local port moves 16-bit words, with per-byte write enables
// - 32K bytes, 64K with expansion
// - local accesses never touch system bus
// - battery mode inhibits access cycles
`timescale 1ns/1ps
`default_nettype none
`include "dpram_regs.svh"

module dual_port_ram_control
  import dpram_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // local processor port, same clock
  input  wire logic        loc_req,
  input  wire logic [19:0] loc_addr,
  input  wire logic        loc_we,
  input  wire logic [1:0]  loc_be,
  input  wire logic [15:0] loc_wdata,
  output var  logic        loc_ack,
  output var  logic        loc_miss,
  output var  logic [15:0] loc_rdata,
  // system bus slave port, asynchronous pins
  input  wire logic        sys_req,
  input  wire logic [19:0] sys_addr,
  input  wire logic        sys_we,
  input  wire logic        sys_byte,
  input  wire logic [15:0] sys_wdata,
  output var  logic        sys_ack,
  output var  logic [15:0] sys_rdata,
  // jumpers and power
  input  wire logic [16:0] base_jumper,
  input  wire logic [1:0]  prot_first,
  input  wire logic [2:0]  prot_count,
  input  wire logic        exp_fitted,
  input  wire logic        battery_mode,
  // status
  output var  logic        refresh_active,
  output var  logic        local_active,
  output var  logic        system_active
);

  // ---------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------
  function automatic logic in_array(input logic [20:0] off,
                                    input logic        exp);
    in_array = exp ? (off < `EXP_LIMIT) : (off < `BASE_LIMIT);
  endfunction

  function automatic logic [2:0] seg_of(input logic [20:0] off,
                                        input logic        exp);
    logic [20:0] s;
    s = exp ? (off >> `SEG_SHIFT_EXP) : (off >> `SEG_SHIFT_BASE);
    seg_of = {1'b0, s[1:0]};
  endfunction

  // ---------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------
  localparam int PW = 63;
  logic [PW-1:0] pin_raw;
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_s;

  assign pin_raw = {sys_req, sys_addr, sys_we, sys_byte, sys_wdata,
                    base_jumper, prot_first, prot_count, exp_fitted,
                    battery_mode};

  // address and data are held stable by the master around the request,
  // so all lanes settle together with the request bit
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta <= '0;
      pin_s    <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_s    <= pin_meta;
    end
  end

  logic        s_req;
  logic [19:0] s_addr;
  logic        s_we;
  logic        s_byte;
  logic [15:0] s_wdata;
  logic [16:0] s_base;
  logic [1:0]  s_pfirst;
  logic [2:0]  s_pcount;
  logic        s_exp;
  logic        s_batt;

  assign {s_req, s_addr, s_we, s_byte, s_wdata, s_base, s_pfirst,
          s_pcount, s_exp, s_batt} = pin_s;

  // ---------------------------------------------------------------------
  // local decode
  // ---------------------------------------------------------------------
  logic [20:0] loc_off;
  logic        loc_hit;

  // fixed at zero, independent of the system-side base
  assign loc_off = {1'b0, loc_addr} - {1'b0, `LOCAL_BASE};
  assign loc_hit = in_array(loc_off, s_exp);

  // ---------------------------------------------------------------------
  // system decode
  // ---------------------------------------------------------------------
  logic [20:0] sys_base_addr;
  logic [20:0] sys_off;
  logic [2:0]  sys_seg;
  logic [3:0]  prot_end;
  logic        sys_hit;
  logic        sys_prot;

  assign sys_base_addr = {1'b0, s_base, 3'h0};
  assign sys_off = {1'b0, s_addr} - sys_base_addr;
  assign sys_hit = ({1'b0, s_addr} >= sys_base_addr) &&
                   in_array(sys_off, s_exp);
  assign sys_seg  = seg_of(sys_off, s_exp);
  assign prot_end = {2'h0, s_pfirst} + {1'b0, s_pcount};
  assign sys_prot = ({1'b0, sys_seg} >= {2'h0, s_pfirst}) &&
                    ({1'b0, sys_seg} < prot_end);

  // ---------------------------------------------------------------------
  // refresh request
  // ---------------------------------------------------------------------
  logic        refresh_pending;
  logic        refresh_grant;
  arb_state_e  state;
  cnt_t        cnt;

  assign refresh_grant = (state == ST_IDLE) && refresh_pending;

  refresh_timer u_refresh (
    .clk     (clk),
    .rst     (rst),
    .served  (refresh_grant),
    .pending (refresh_pending)
  );

  // ---------------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------------
  logic loc_grant;
  logic sys_grant;
  logic cyc_end;

  // battery mode leaves refresh running but grants no access
  assign loc_grant = (state == ST_IDLE) && !refresh_pending &&
                     !s_batt && loc_req && loc_hit;
  assign sys_grant = (state == ST_IDLE) && !refresh_pending &&
                     !s_batt && !(loc_req && loc_hit) &&
                     s_req && sys_hit && !sys_prot;
  assign cyc_end = (cnt == cnt_t'(0));

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (refresh_pending) begin
            state <= ST_REFRESH;
            cnt   <= cnt_t'(`REFRESH_CYC - 1);
          end else if (loc_grant) begin
            state <= ST_LOCAL;
            cnt   <= cnt_t'(`ACCESS_CYC - 1);
          end else if (sys_grant) begin
            state <= ST_SYSTEM;
            cnt   <= cnt_t'(`ACCESS_CYC - 1);
          end
        end
        ST_REFRESH, ST_LOCAL: begin
          // no preemption: a waiting request only shapes the next grant
          if (cyc_end) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - cnt_t'(1);
          end
        end
        ST_SYSTEM: begin
          if (cyc_end) begin
            state <= ST_SYS_HOLD;
          end else begin
            cnt <= cnt - cnt_t'(1);
          end
        end
        ST_SYS_HOLD: begin
          if (!s_req) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------
  // latched operation
  // ---------------------------------------------------------------------
  logic [14:0] op_idx;
  logic [1:0]  op_be;
  logic [15:0] op_wdata;
  logic        op_we;
  logic        op_byte;
  logic        op_lane;

  always_ff @(posedge clk) begin
    if (rst) begin
      op_idx   <= '0;
      op_be    <= '0;
      op_wdata <= '0;
      op_we    <= 1'b0;
      op_byte  <= 1'b0;
      op_lane  <= 1'b0;
    end else if (loc_grant) begin
      op_idx   <= loc_off[15:1];
      op_be    <= loc_be;
      op_wdata <= loc_wdata;
      op_we    <= loc_we;
      op_byte  <= 1'b0;
      op_lane  <= 1'b0;
    end else if (sys_grant) begin
      op_idx   <= sys_off[15:1];
      op_we    <= s_we;
      op_byte  <= s_byte;
      op_lane  <= sys_off[0];
      if (s_byte) begin
        op_be    <= sys_off[0] ? 2'h2 : 2'h1;
        op_wdata <= {s_wdata[7:0], s_wdata[7:0]};
      end else begin
        op_be    <= 2'h3;
        op_wdata <= s_wdata;
      end
    end
  end

  // ---------------------------------------------------------------------
  // memory array
  // ---------------------------------------------------------------------
  word_t mem [0:`MEM_WORDS-1];
  logic  access_end;
  word_t rd_word;

  assign access_end = cyc_end &&
                      ((state == ST_LOCAL) || (state == ST_SYSTEM));
  assign rd_word = mem[op_idx];

  // a write caught by battery mode mid-cycle is dropped, not half done
  always_ff @(posedge clk) begin
    if (access_end && op_we && !s_batt) begin
      if (op_be[0]) begin
        mem[op_idx][7:0] <= op_wdata[7:0];
      end
      if (op_be[1]) begin
        mem[op_idx][15:8] <= op_wdata[15:8];
      end
    end
  end

  // ---------------------------------------------------------------------
  // local answer, never drives the system side
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      loc_ack   <= 1'b0;
      loc_miss  <= 1'b0;
      loc_rdata <= '0;
    end else begin
      loc_ack  <= access_end && (state == ST_LOCAL);
      loc_miss <= (state == ST_IDLE) && loc_req && !loc_hit;
      if (access_end && (state == ST_LOCAL) && !op_we) begin
        loc_rdata <= rd_word;
      end
    end
  end

  // ---------------------------------------------------------------------
  // system answer, held until the master drops its request
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      sys_ack   <= 1'b0;
      sys_rdata <= '0;
    end else begin
      if (access_end && (state == ST_SYSTEM)) begin
        sys_ack <= 1'b1;
      end else if ((state == ST_SYS_HOLD) && !s_req) begin
        sys_ack <= 1'b0;
      end
      if (access_end && (state == ST_SYSTEM) && !op_we) begin
        if (op_byte) begin
          sys_rdata <= {8'h00, op_lane ? rd_word[15:8] : rd_word[7:0]};
        end else begin
          sys_rdata <= rd_word;
        end
      end
    end
  end

  // ---------------------------------------------------------------------
  // status
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      refresh_active <= 1'b0;
      local_active   <= 1'b0;
      system_active  <= 1'b0;
    end else begin
      refresh_active <= refresh_grant || ((state == ST_REFRESH) &&
                                          !cyc_end);
      local_active   <= loc_grant || ((state == ST_LOCAL) && !cyc_end);
      system_active  <= sys_grant || ((state == ST_SYSTEM) && !cyc_end);
    end
  end

endmodule

`default_nettype wire

// *** bench/dpram_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module dpram_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [19:0] loc_addr,
  input wire logic        loc_ack,
  input wire logic        loc_miss,
  input wire logic        sys_ack,
  input wire logic        battery_mode,
  input wire logic        refresh_active,
  input wire logic        local_active,
  input wire logic        system_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_ack_pulse: assert property (loc_ack |=> !loc_ack)
    else $error("ack too long");
  a_local_len: assert property ($rose(local_active) |->
    ##13 (loc_ack && !local_active)) else $error("local length");
  a_sys_len: assert property ($rose(system_active) |->
    ##13 (sys_ack && !system_active)) else $error("system length");
  a_ref_len: assert property ($rose(refresh_active) |->
    ##24 refresh_active ##1 !refresh_active) else $error("refresh length");
  a_one_owner: assert property ($onehot0({refresh_active,
    local_active, system_active})) else $error("two owners");
  // two sync flops on the pin, so four samples give margin
  a_batt_stop: assert property (battery_mode [*4] |=>
    !$rose(local_active) && !$rose(system_active)) else $error("battery");
  a_miss_addr: assert property (loc_miss |->
    $past(loc_addr) >= 20'h08000) else $error("false miss");
  a_zero_base: assert property ($rose(local_active) |->
    $past(loc_addr) < 20'h10000) else $error("local base");
  a_local_quiet: assert property (local_active |-> !sys_ack)
    else $error("system bus busy");
  c_ref: cover property ($rose(refresh_active));
  c_sys: cover property ($rose(sys_ack));
  c_miss: cover property (loc_miss);
endmodule
bind dual_port_ram_control dpram_checker i_chk (.clk, .rst, .loc_addr,
  .loc_ack, .loc_miss, .sys_ack, .battery_mode, .refresh_active,
  .local_active, .system_active);
`default_nettype wire

// *** bench/sys_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sys_master_model
  import dpram_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  sys_ack,
  input  wire word_t sys_rdata,
  output var  logic  sys_req,
  output var  addr_t sys_addr,
  output var  logic  sys_we,
  output var  logic  sys_byte,
  output var  word_t sys_wdata
);
  initial {sys_req, sys_addr, sys_we, sys_byte, sys_wdata} = '0;
  // no ack within the limit is a bus timeout, ok stays low
  task automatic xfer(input addr_t a, input logic w, b, input word_t d,
                      input int lag, output word_t q, output logic ok);
    int n;
    @(negedge clk);
    {sys_addr, sys_we, sys_byte, sys_wdata} = {a, w, b, d};
    repeat (2) @(negedge clk);
    sys_req = 1;
    ok = 0;
    for (n = 0; n < 80 && !ok; n++) @(posedge clk) #1 ok = sys_ack;
    q = sys_rdata;
    repeat (lag) @(negedge clk);
    @(negedge clk);
    sys_req = 0;
    for (n = 0; n < 9 && sys_ack; n++) @(negedge clk);
    @(negedge clk);
    // released address and data lines show the inverse, never the last value
    {sys_addr, sys_wdata} = {~a, ~d};
  endtask
endmodule
`default_nettype wire

// *** bench/dual_port_ram_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin comparisons++; if ((g) !== (w)) begin \
  num_errors++; $display("BAD %0t %h not %h", $time, g, w); end end
module dual_port_ram_control_tb;
  import dpram_pkg::*;
  localparam addr_t B = 20'h40008;
  logic        clk = 0, rst = 1, loc_req = 0, loc_we = 0, ok;
  logic        exp_fitted = 0, battery_mode = 0, saw_miss = 0;
  logic        loc_ack, loc_miss, sys_req, sys_we, sys_byte, sys_ack;
  logic        refresh_active, local_active, system_active;
  logic [1:0]  loc_be = 0, prot_first = 0;
  logic [2:0]  prot_count = 0;
  logic [16:0] base_jumper = 17'h08001;
  addr_t       loc_addr = 0, sys_addr;
  word_t       loc_wdata = 0, loc_rdata, sys_wdata, sys_rdata, q;
  int          num_errors = 0, comparisons = 0, n_ack = 0, n_ref = 0;
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    n_ref <= n_ref + int'(refresh_active);
    saw_miss <= saw_miss | loc_miss;
    n_ack <= n_ack + int'(loc_ack);
  end
  dual_port_ram_control i_dut (.clk, .rst, .loc_req, .loc_addr, .loc_we,
    .loc_be, .loc_wdata, .loc_ack, .loc_miss, .loc_rdata, .sys_req,
    .sys_addr, .sys_we, .sys_byte, .sys_wdata, .sys_ack, .sys_rdata,
    .base_jumper, .prot_first, .prot_count, .exp_fitted, .battery_mode,
    .refresh_active, .local_active, .system_active);
  sys_master_model i_bus (.clk, .sys_ack, .sys_rdata, .sys_req, .sys_addr,
    .sys_we, .sys_byte, .sys_wdata);
  task automatic lx(input addr_t a, input logic w, input logic [1:0] e,
                    input word_t d);
    int n;
    @(negedge clk);
    {loc_req, loc_addr, loc_we, loc_be, loc_wdata} = {1'b1, a, w, e, d};
    ok = 0;
    for (n = 0; n < 60 && !ok; n++) @(posedge clk) #1 ok = loc_ack;
    q = loc_rdata;
    @(negedge clk);
    {loc_req, loc_addr, loc_wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic sx(input addr_t a, input logic w, b, input word_t d);
    i_bus.xfer(a, w, b, d, 0, q, ok);
  endtask
  task t_local;
    lx(20'h00010, 1, 2'b11, 16'h1234);
    lx(20'h00010, 1, 2'b10, 16'hab00);
    lx(20'h00010, 0, 2'b11, 16'h0);
    `CHK(q, 16'hab34)
    lx(20'h08000, 1, 2'b11, 16'h7777);
    `CHK({ok, saw_miss}, 2'b01)
    exp_fitted = 1;
    lx(20'h08000, 1, 2'b11, 16'h7777);
    lx(20'h08000, 0, 2'b11, 16'h0);
    `CHK(q, 16'h7777)
    exp_fitted = 0;
    battery_mode = 1;
    repeat (3) @(negedge clk);
    lx(20'h00010, 0, 2'b11, 16'h0);
    `CHK(ok, 1'b0)
    battery_mode = 0;
    lx(20'h00010, 0, 2'b11, 16'h0);
    `CHK(q, 16'hab34)
    $display("local test done");
  endtask
  task t_sys;
    sx(B + 20'h20, 1, 0, 16'hc3a5);
    sx(B + 20'h21, 1, 1, 16'h005a);
    lx(20'h00020, 0, 2'b11, 16'h0);
    `CHK(q, 16'h5aa5)
    sx(B + 20'h20, 0, 1, 16'h0);
    `CHK(q, 16'h00a5)
    sx(B + 20'h21, 0, 1, 16'h0);
    `CHK(q, 16'h005a)
    sx(B - 20'h8, 0, 0, 16'h0);
    `CHK(ok, 1'b0)
    base_jumper = 17'h0;
    sx(20'h00020, 0, 0, 16'h0);
    `CHK(q, 16'h5aa5)
    base_jumper = 17'h08001;
    sx(B + 20'h8000, 0, 0, 16'h0);
    `CHK(ok, 1'b0)
    {prot_first, prot_count} = {2'd1, 3'd1};
    sx(B + 20'h2000, 1, 0, 16'h1111);
    `CHK(ok, 1'b0)
    sx(B + 20'h4000, 1, 0, 16'h3333);
    `CHK(ok, 1'b1)
    prot_count = 0;
    sx(B + 20'h2000, 1, 0, 16'h4444);
    `CHK(ok, 1'b1)
    // expansion doubles the segment size, so segment 1 moves up
    {exp_fitted, prot_count} = {1'b1, 3'd1};
    sx(B + 20'h2000, 1, 0, 16'h5555);
    `CHK(ok, 1'b1)
    sx(B + 20'h4000, 1, 0, 16'h6666);
    `CHK(ok, 1'b0)
    {exp_fitted, prot_count} = {1'b0, 3'd0};
    $display("system test done");
  endtask
  task automatic t_prio;
    int start;
    int seen;
    start = n_ack;
    fork
      begin
        i_bus.xfer(B, 0, 0, 16'h0, 5, q, ok);
        seen = n_ack - start;
      end
      begin
        @(negedge clk);
        {loc_req, loc_addr, loc_we} = {1'b1, 20'h00040, 1'b0};
        repeat (2) @(posedge loc_ack);
        @(negedge clk);
        loc_req = 0;
      end
    join
    `CHK(seen, 2)
    $display("priority test done");
  endtask
  task automatic t_ref;
    int start;
    start = n_ref;
    repeat (150) begin
      lx(20'h00010, 0, 2'b11, 16'h0);
      `CHK(q, 16'hab34)
    end
    `CHK(n_ref - start > 0, 1'b1)
    $display("refresh test done");
  endtask
  task test_done;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 0;
    repeat (3) @(negedge clk);
    t_local;
    t_sys;
    t_prio;
    t_ref;
    test_done;
  end
  // whole run is some 3000 cycles, so this only fires on a hang
  initial begin
    #160000;
    num_errors++;
    test_done;
  end
endmodule
`default_nettype wire
